// [src/ulsx_params.svh]
// Purpose: Offsets, field positions, reset values for line status block
// Assumes: APB byte addresses are the word index times four
// Notes: Printed offsets are not multiples of four, so kept as indices
`ifndef ULSX_PARAMS_SVH
`define ULSX_PARAMS_SVH
// ----------------------------------------
// Register indices and address width
// ----------------------------------------
`define ULSX_IDX_DATA 16'h2500
`define ULSX_IDX_DIVHI 16'h2501
`define ULSX_IDX_FIFOCTL 16'h2502
`define ULSX_IDX_LINECTL 16'h2503
`define ULSX_IDX_RXTHR 16'h2504
`define ULSX_IDX_LSTAT 16'h2505
`define ULSX_IDX_DIVEXT 16'h2507
`define ULSX_IDX_DIVLO 16'h2500
`define ULSX_ADDR_W 18
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ULSX_LCR_DIVISOR_ACCESS_SELECT 7
`define ULSX_SEL_RXTHR 3'h2
`define ULSX_SEL_FILL 3'h5
`define ULSX_DIVEXT_RST 8'h10
`define ULSX_RXTHR_RST 8'h00
`define ULSX_LINECTL_RST 8'h03
`define ULSX_TRIG_RST 2'h3
`define ULSX_FIFO_DEPTH 16
`define ULSX_CNT_W 5
`endif

// [src/ulsx_pkg.sv]
// Purpose: Types for the line status and FIFO extension block
// Assumes: Nothing beyond the params header
// Notes: Receive engine state only
package ulsx_pkg;
	typedef enum logic [2:0] {
		ULSX_IDLE,
		ULSX_START,
		ULSX_DATA,
		ULSX_PARITY,
		ULSX_STOP,
		ULSX_BRK_WAIT
	} ulsx_rx_state_type;
endpackage

// [src/ulsx_uart.sv]
// Purpose: Line status flags, fill counters, divisor extension, selector
//   and receive threshold, over a small receiver and transmit counter
// Assumes: APB slave, 100 MHz pclk, asynchronous active-low reset
// Notes: Receiver samples once per sixteen 16x baud ticks, at the bit centre
//
// Notes on behaviour
// [RULE_01] Error summary set on errors, read clears
// [RULE_02] Transmitter all-empty: FIFO and shifter empty
// [RULE_03] Transmit FIFO empty flag, holding-empty interrupt
// [RULE_04] Break after one full character of low
// [RULE_05] Break pushes zero byte, waits start
// [RULE_06] Framing error for head character
// [RULE_07] Parity error for head character
// [RULE_08] Overrun when character completes, FIFO full
// [RULE_09] Overrun overwrites shifter, FIFO kept intact
// [RULE_10] Status flags clear on read, raise interrupt
// [RULE_11] Data present while receive FIFO non-empty
// [RULE_12] Divisor extension, reset 0x10, divisor access only
// [RULE_13] Write-only selector: 0 default, 2, 5
// [RULE_14] Selector 5: transmit fill at line-control address
// [RULE_15] Selector 2: receive threshold, zero uses trigger
// [RULE_16] Nonzero threshold: interrupt when count reaches it
// [RULE_17] Status address: read status, write selector
// [RULE_18] Line control bit 7 selects divisor access
// [RULE_19] Trigger field picks 1, 4, 8, 14
// [RULE_20] Selector 5: receive fill at threshold address
// [RULE_21] Selector persists; others mean default access
`include "ulsx_params.svh"
module ulsx_uart (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ULSX_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_line,
	input wire logic tx_shift_busy,
	input wire logic tx_pop,
	output logic tx_fifo_empty_flag,
	output logic tx_all_empty,
	output logic line_status_irq,
	output logic tx_empty_irq,
	output logic rx_data_irq,
	output logic [23:0] baud_divisor
);
	localparam int DEPTH = `ULSX_FIFO_DEPTH;
	localparam int CW = `ULSX_CNT_W;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic [7:0] line_control_q, div_lo_q, divisor_high_byte_q;
	logic [7:0] divisor_extension_q, rx_irq_threshold_q;
	logic [2:0] extra_feature_select_q;
	logic [1:0] rx_trigger_select_q;
	logic [CW-1:0] rx_cnt_q, tx_cnt_q;
	logic [7:0] line_status;

	wire [15:0] idx = paddr[`ULSX_ADDR_W-1:2];
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;
	wire divisor_access_select = line_control_q[`ULSX_LCR_DIVISOR_ACCESS_SELECT]; // RULE_18
	wire sel_thr = extra_feature_select_q == `ULSX_SEL_RXTHR; // RULE_21
	wire sel_fill = extra_feature_select_q == `ULSX_SEL_FILL; // RULE_21
	wire a_data = idx == `ULSX_IDX_DATA;
	wire a_divhi = idx == `ULSX_IDX_DIVHI;
	wire a_fctl = idx == `ULSX_IDX_FIFOCTL;
	wire a_lctl = idx == `ULSX_IDX_LINECTL;
	wire a_thr = idx == `ULSX_IDX_RXTHR;
	wire a_lst = idx == `ULSX_IDX_LSTAT;
	wire a_dext = idx == `ULSX_IDX_DIVEXT;
	wire mapped = a_data | a_divhi | a_fctl | a_lctl | a_thr | a_lst
		| a_dext;
	// Divisor bytes shadow data and high addresses while access selected
	wire wr_div_lo = wr & a_data & divisor_access_select; // RULE_18
	wire wr_div_hi = wr & a_divhi & divisor_access_select; // RULE_18
	wire wr_tx = wr & a_data & ~divisor_access_select;
	wire wr_dext = wr & a_dext & divisor_access_select; // RULE_12
	wire wr_sel = wr & a_lst; // RULE_17
	wire wr_lctl = wr & a_lctl;
	wire wr_thr = wr & a_thr & sel_thr; // RULE_15
	wire wr_fctl = wr & a_fctl;
	wire rd_lst = rd & a_lst; // RULE_17
	wire rd_rx = rd & a_data & ~divisor_access_select;

	// Read mux; fill counters replace line control and threshold data
	logic [7:0] rmux;
	always_comb begin
		rmux = 8'h00;
		if (a_lst)
			rmux = line_status; // RULE_17
		else if (a_lctl)
			rmux = sel_fill ? 8'(tx_cnt_q) : line_control_q; // RULE_14
		else if (a_thr)
			rmux = sel_fill ? 8'(rx_cnt_q) // RULE_20
				: (sel_thr ? rx_irq_threshold_q : 8'h00); // RULE_15
		else if (a_dext)
			rmux = divisor_access_select ? divisor_extension_q : 8'h00;
		else if (a_divhi)
			rmux = divisor_access_select ? divisor_high_byte_q : 8'h00;
		else if (a_data)
			rmux = divisor_access_select ? div_lo_q : 8'h00;
	end

	// ----------------------------------------
	// APB answer, zero wait state
	// ----------------------------------------
	// Single-cycle access; unmapped addresses answer with an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= {24'h00_0000, rmux};
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_control_q <= `ULSX_LINECTL_RST;
			div_lo_q <= 8'h00;
			divisor_high_byte_q <= 8'h00;
			divisor_extension_q <= `ULSX_DIVEXT_RST; // RULE_12
			extra_feature_select_q <= 3'h0;
			rx_irq_threshold_q <= `ULSX_RXTHR_RST;
			rx_trigger_select_q <= `ULSX_TRIG_RST; // RULE_19
		end else if (pready) begin
			if (wr_lctl && !sel_fill)
				line_control_q <= pwdata[7:0];
			if (wr_div_lo)
				div_lo_q <= pwdata[7:0];
			if (wr_div_hi)
				divisor_high_byte_q <= pwdata[7:0];
			if (wr_dext)
				divisor_extension_q <= pwdata[7:0]; // RULE_12
			if (wr_sel)
				extra_feature_select_q <= pwdata[2:0]; // RULE_13
			if (wr_thr)
				rx_irq_threshold_q <= pwdata[7:0]; // RULE_15
			if (wr_fctl)
				rx_trigger_select_q <= pwdata[7:6];
		end
	end

	// Extension, high and low bytes together set the baud rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			baud_divisor <= 24'h00_0000;
		else
			baud_divisor <= {divisor_extension_q, divisor_high_byte_q,
				div_lo_q}; // RULE_12
	end

	// ----------------------------------------
	// 16x baud tick
	// ----------------------------------------
	logic [23:0] baud_cnt_q;
	wire baud_tick = baud_cnt_q >= baud_divisor; // New divisor acts at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			baud_cnt_q <= 24'h00_0000;
		else
			baud_cnt_q <= baud_tick ? 24'h00_0000 : baud_cnt_q + 24'h00_0001;
	end

	// Line input synchroniser
	logic rx_meta_q, rx_sync_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
		end else begin
			rx_meta_q <= rx_line;
			rx_sync_q <= rx_meta_q;
		end
	end

	// ----------------------------------------
	// Receive engine
	// ----------------------------------------
	ulsx_pkg::ulsx_rx_state_type st_q;
	logic [3:0] sub_q;
	logic [2:0] bit_q;
	logic [7:0] shift_q;
	logic par_q, all_low_q;
	wire [2:0] nbits = {1'b0, line_control_q[1:0]} + 3'h4;
	wire par_en = line_control_q[3];
	wire par_even = line_control_q[4];
	wire mid = baud_tick & (sub_q == 4'hF);
	// Expected parity of data plus parity bit: even gives zero
	wire par_bad = par_en & ((par_q ^ rx_sync_q) != ~par_even);
	logic push, push_fe, push_pe, push_brk;
	logic [7:0] push_data;
	always_comb begin
		push_fe = ~rx_sync_q;
		push_brk = all_low_q & ~rx_sync_q; // RULE_04
		push_data = push_brk ? 8'h00 : shift_q >> (3'h7 - nbits); // RULE_05
		push = mid & (st_q == ulsx_pkg::ULSX_STOP);
		push_pe = par_q & par_en;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ulsx_pkg::ULSX_IDLE;
			sub_q <= 4'h0;
			bit_q <= 3'h0;
			shift_q <= 8'h00;
			par_q <= 1'b0;
			all_low_q <= 1'b0;
		end else if (baud_tick) begin
			sub_q <= sub_q + 4'h1;
			unique case (st_q)
			ulsx_pkg::ULSX_IDLE: begin
				sub_q <= 4'h8;
				if (!rx_sync_q)
					st_q <= ulsx_pkg::ULSX_START;
			end
			ulsx_pkg::ULSX_START: if (sub_q == 4'hF) begin
				all_low_q <= 1'b1;
				bit_q <= 3'h0;
				par_q <= 1'b0;
				st_q <= rx_sync_q ? ulsx_pkg::ULSX_IDLE
					: ulsx_pkg::ULSX_DATA;
			end
			ulsx_pkg::ULSX_DATA: if (sub_q == 4'hF) begin
				// New bits overwrite the shifter even while overrun
				shift_q <= {rx_sync_q, shift_q[7:1]}; // RULE_09
				par_q <= par_q ^ rx_sync_q;
				all_low_q <= all_low_q & ~rx_sync_q;
				bit_q <= bit_q + 3'h1;
				if (bit_q == nbits)
					st_q <= par_en ? ulsx_pkg::ULSX_PARITY
						: ulsx_pkg::ULSX_STOP;
			end
			ulsx_pkg::ULSX_PARITY: if (sub_q == 4'hF) begin
				par_q <= par_bad;
				all_low_q <= all_low_q & ~rx_sync_q;
				st_q <= ulsx_pkg::ULSX_STOP;
			end
			ulsx_pkg::ULSX_STOP: if (sub_q == 4'hF) begin
				if (!par_en)
					par_q <= 1'b0;
				// Low stop or break: wait for idle, not a false start
				st_q <= push_fe ? ulsx_pkg::ULSX_BRK_WAIT // RULE_05
					: ulsx_pkg::ULSX_IDLE;
			end
			ulsx_pkg::ULSX_BRK_WAIT:
				if (rx_sync_q)
					st_q <= ulsx_pkg::ULSX_IDLE; // RULE_05
			endcase
		end
	end

	// ----------------------------------------
	// Receive FIFO with per-entry error bits
	// ----------------------------------------
	logic [10:0] rx_mem [DEPTH];
	logic [3:0] rx_wp_q, rx_rp_q;
	wire rx_full = rx_cnt_q == CW'(DEPTH);
	wire rx_empty = rx_cnt_q == '0;
	wire rx_wr = push & ~rx_full; // RULE_08
	wire rx_rd = pready & rd_rx & ~rx_empty;
	wire [10:0] rx_head = rx_mem[rx_rp_q];
	always_ff @(posedge pclk)
		if (rx_wr)
			rx_mem[rx_wp_q] <= {push_brk, push_fe, push_pe & ~push_brk,
				push_data};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wp_q <= 4'h0;
			rx_rp_q <= 4'h0;
			rx_cnt_q <= '0;
		end else begin
			if (rx_wr)
				rx_wp_q <= rx_wp_q + 4'h1;
			if (rx_rd)
				rx_rp_q <= rx_rp_q + 4'h1;
			rx_cnt_q <= rx_cnt_q + CW'(rx_wr) - CW'(rx_rd);
		end
	end

	// ----------------------------------------
	// Sticky status flags
	// ----------------------------------------
	// Head entry errors latch when that entry reaches the head; a new
	// event in the read cycle wins over the clear
	logic brk_q, fe_q, pe_q, oe_q, err_q, head_seen_q;
	wire clr = rd_lst & pready;
	wire set_oe = push & rx_full; // RULE_08
	wire head_ev = ~rx_empty & ~head_seen_q;
	wire set_brk = head_ev & rx_head[10];
	wire set_fe = head_ev & rx_head[9]; // RULE_06
	wire set_pe = head_ev & rx_head[8]; // RULE_07
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brk_q <= 1'b0;
			fe_q <= 1'b0;
			pe_q <= 1'b0;
			oe_q <= 1'b0;
			err_q <= 1'b0;
			head_seen_q <= 1'b0;
		end else begin
			head_seen_q <= ~rx_empty & ~rx_rd;
			brk_q <= set_brk | (brk_q & ~clr); // RULE_04 RULE_10
			fe_q <= set_fe | (fe_q & ~clr); // RULE_06 RULE_10
			pe_q <= set_pe | (pe_q & ~clr); // RULE_07 RULE_10
			oe_q <= set_oe | (oe_q & ~clr); // RULE_08 RULE_10
			err_q <= set_brk | set_fe | set_pe | (err_q & ~clr); // RULE_01
		end
	end

	// ----------------------------------------
	// Transmit FIFO occupancy
	// ----------------------------------------
	wire tx_wr = pready & wr_tx & (tx_cnt_q != CW'(DEPTH));
	wire tx_rd = tx_pop & (tx_cnt_q != '0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_cnt_q <= '0;
		else
			tx_cnt_q <= tx_cnt_q + CW'(tx_wr) - CW'(tx_rd);
	end
	wire [CW-1:0] tx_next = tx_cnt_q + CW'(tx_wr) - CW'(tx_rd);

	assign line_status = {err_q, tx_all_empty, tx_fifo_empty_flag, brk_q,
		fe_q, pe_q, oe_q, ~rx_empty}; // RULE_11

	// ----------------------------------------
	// Flags and interrupts
	// ----------------------------------------
	// Trigger level from fifo control unless threshold is nonzero
	logic [CW-1:0] trig;
	always_comb begin
		unique case (rx_trigger_select_q) // RULE_19
		2'h0: trig = CW'(1);
		2'h1: trig = CW'(4);
		2'h2: trig = CW'(8);
		2'h3: trig = CW'(14);
		endcase
	end
	wire [7:0] level = (rx_irq_threshold_q != 8'h00) ? rx_irq_threshold_q
		: 8'(trig); // RULE_15 RULE_16
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_fifo_empty_flag <= 1'b1;
			tx_all_empty <= 1'b1;
			tx_empty_irq <= 1'b1;
			line_status_irq <= 1'b0;
			rx_data_irq <= 1'b0;
		end else begin
			tx_fifo_empty_flag <= tx_next == '0; // RULE_03
			tx_empty_irq <= tx_next == '0; // RULE_03
			tx_all_empty <= (tx_next == '0) & ~tx_shift_busy; // RULE_02
			line_status_irq <= brk_q | fe_q | pe_q | oe_q; // RULE_10
			rx_data_irq <= 8'(rx_cnt_q) >= level; // RULE_16
		end
	end
endmodule

// [testbench/ulsx_monitor.sv]
// Purpose: Port checks on the line status block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound from the bench top
module ulsx_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_fifo_empty_flag,
	input wire logic tx_all_empty,
	input wire logic line_status_irq,
	input wire logic tx_empty_irq,
	input wire logic rx_data_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Decode of bus phases
	// ----
	wire setup = psel && !penable;
	wire rd_st = psel && penable && pready && !pwrite && paddr == 18'h09414;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// Properties
	// ----
	property p_unmap; setup && paddr == 18'h09418 |=> pready && pslverr;
	endproperty
	a_unmap: assert property (p_unmap) else $error("no error answer");
	property p_sum; rd_st && |prdata[4:2] |-> prdata[7]; endproperty
	a_sum: assert property (p_sum) else $error("summary low");
	property p_clr; rd_st |-> ##[1:2] !line_status_irq; endproperty
	a_clr: assert property (p_clr) else $error("read kept irq");
	property p_lsi; rd_st && |prdata[4:1] |-> line_status_irq; endproperty
	a_lsi: assert property (p_lsi) else $error("no status irq");
	property p_tx;
		rd_st |-> prdata[6:5] ==
			{$past(tx_all_empty), $past(tx_fifo_empty_flag)};
	endproperty
	a_tx: assert property (p_tx) else $error("empty bits");
	property p_tx_fifo_empty_flag; $rose(tx_fifo_empty_flag) |-> ##[0:1] tx_empty_irq;
	endproperty
	a_tx_fifo_empty_flag: assert property (p_tx_fifo_empty_flag) else $error("no empty irq");
	property p_tx_all_empty; tx_all_empty |-> tx_fifo_empty_flag; endproperty
	a_tx_all_empty: assert property (p_tx_all_empty) else $error("all empty");
	property p_rxi; rd_st && rx_data_irq |-> prdata[0]; endproperty
	a_rxi: assert property (p_rxi) else $error("irq, no data");
	// Main scenarios reached
	c_ovr: cover property (rd_st && prdata[1]);
	c_brk: cover property (rd_st && prdata[4]);
	c_rxi: cover property (rd_st && rx_data_irq);
endmodule

// [testbench/ulsx_line_model.sv]
// Purpose: Remote sender on the receive line
// Assumes: Ten-bit frames; a parity bit rides in the top data bit
// Notes: Line rests high between frames
module ulsx_line_model #(
	parameter int BIT = 32
) (
	input wire logic pclk,
	output logic rx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rx_line = 1'b1;
	// One frame; a low stop bit makes a framing fault
	task automatic send(input logic [7:0] b, input logic stp = 1'b1);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (BIT) @(posedge pclk);
		end
		rx_line <= 1'b1;
		repeat (BIT) @(posedge pclk);
	endtask
	// Low for longer than a whole character
	task automatic brk();
		rx_line <= 1'b0;
		repeat (12 * BIT) @(posedge pclk);
		rx_line <= 1'b1;
		repeat (2 * BIT) @(posedge pclk);
	endtask
endmodule

// [testbench/ulsx_uart_tb.sv]
// Purpose: Self-checking bench for the line status block
// Assumes: Divisor of one, so a bit lasts 32 clocks
// Notes: Reads checked against a queue of notes
module ulsx_uart_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [17:0] ad_dat = 18'h09400, ad_dhi = 18'h09404;
	localparam logic [17:0] ad_fct = 18'h09408, ad_lct = 18'h0940C;
	localparam logic [17:0] ad_lvl = 18'h09410, ad_sta = 18'h09414;
	localparam logic [17:0] ad_dxt = 18'h0941C, ad_bad = 18'h09418;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, rx_line, tx_fifo_empty_flag, tx_all_empty;
	logic line_status_irq, tx_empty_irq, rx_data_irq;
	logic tx_shift_busy = 1'b0, tx_pop = 1'b0;
	logic [23:0] baud_divisor;
	logic [34:0] e_q[$], m_q[$], got;
	int n_mismatch = 0, checks = 0, cyc = 0, seed = 82;
	always #5 pclk = ~pclk;
	ulsx_uart i_ulsx_uart (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_line(rx_line), .tx_shift_busy(tx_shift_busy), .tx_pop(tx_pop),
		.tx_fifo_empty_flag(tx_fifo_empty_flag), .tx_all_empty(tx_all_empty),
		.line_status_irq(line_status_irq), .tx_empty_irq(tx_empty_irq),
		.rx_data_irq(rx_data_irq), .baud_divisor(baud_divisor));
	ulsx_line_model #(.BIT(32)) i_ulsx_line_model (.pclk(pclk),
		.rx_line(rx_line));
	// ----
	// Bus tasks: request held until pready is seen
	// ----
	task automatic bus(input logic w, input logic [17:0] a,
		input logic [7:0] d, input logic [34:0] e = '0,
		input logic [34:0] m = '0);
		@(posedge pclk);
		if (!w) begin
			e_q.push_back(e);
			m_q.push_back(m);
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	// Irq lines are compared only where im asks for it
	task automatic rd(input logic [17:0] a, input logic [7:0] e,
		input logic [1:0] irq = 2'b00, input logic [1:0] im = 2'b00,
		input logic [7:0] m = 8'hFF, input logic er = 1'b0);
		bus(1'b0, a, 8'h00, {irq, er, 24'h000000, e}, {im, 25'h1FFFFFF, m});
	endtask
	task automatic pop();
		@(posedge pclk);
		tx_pop <= 1'b1;
		@(posedge pclk);
		tx_pop <= 1'b0;
	endtask
	function automatic logic [7:0] rb();
		return 8'($random(seed));
	endfunction
	task automatic send_n(input int n);
		repeat (n) i_ulsx_line_model.send(rb());
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ----
	// Watcher and hang guard
	// ----
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			complete_run();
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			got = {line_status_irq, rx_data_irq, pslverr, prdata};
			checks++;
			if (((got ^ e_q[0]) & m_q[0]) !== 35'h0) begin
				n_mismatch++;
				$display("[FAIL] %0t read %h got %h", $time, paddr, got);
			end
			void'(e_q.pop_front());
			void'(m_q.pop_front());
		end
	end
	// ----
	// Scenarios
	// ----
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(ad_sta, 8'h60);
		rd(ad_bad, 8'h00, 2'b00, 2'b00, 8'hFF, 1'b1);
		wr(ad_lct, 8'h83);
		rd(ad_dxt, 8'h10);
		wr(ad_dxt, 8'h00);
		wr(ad_dhi, 8'h00);
		wr(ad_dat, 8'h01);
		wr(ad_lct, 8'h03);
		checks++;
		if (baud_divisor !== 24'h00_0001) begin
			n_mismatch++;
			$display("[FAIL] %0t divisor %h", $time, baud_divisor);
		end
		$display("done reset and divisor");
		// Transmit fill, drained while the shifter is busy
		wr(ad_dat, rb());
		wr(ad_dat, rb());
		rd(ad_sta, 8'h00);
		wr(ad_sta, 8'h05);
		rd(ad_lct, 8'h02);
		tx_shift_busy <= 1'b1;
		pop();
		pop();
		rd(ad_lct, 8'h00);
		rd(ad_sta, 8'h20);
		tx_shift_busy <= 1'b0;
		rd(ad_sta, 8'h60);
		wr(ad_sta, 8'h07);
		rd(ad_lct, 8'h03);
		rd(ad_lvl, 8'h00);
		$display("done transmit fill");
		// Clean character, then one with a low stop bit
		send_n(1);
		rd(ad_sta, 8'h61);
		rd(ad_dat, 8'h00);
		rd(ad_sta, 8'h60);
		i_ulsx_line_model.send(rb() | 8'h01, 1'b0);
		rd(ad_sta, 8'hE9, 2'b10, 2'b10);
		rd(ad_sta, 8'h61, 2'b00, 2'b10);
		rd(ad_dat, 8'h00);
		i_ulsx_line_model.brk();
		rd(ad_sta, 8'hF1, 2'b10, 2'b10, 8'hF3);
		wr(ad_sta, 8'h05);
		rd(ad_lvl, 8'h01);
		wr(ad_sta, 8'h00);
		rd(ad_dat, 8'h00);
		rd(ad_sta, 8'h60);
		// Seven data bits with odd parity: a good frame, then a bad one
		wr(ad_lct, 8'h0A);
		i_ulsx_line_model.send(8'h80);
		rd(ad_sta, 8'h61);
		rd(ad_dat, 8'h00);
		i_ulsx_line_model.send(8'h00);
		rd(ad_sta, 8'hE5, 2'b10, 2'b10);
		rd(ad_dat, 8'h00);
		wr(ad_lct, 8'h03);
		$display("done receive errors");
		// Threshold of three, then every trigger code at four bytes
		wr(ad_sta, 8'h02);
		wr(ad_lvl, 8'h03);
		rd(ad_lvl, 8'h03);
		send_n(2);
		rd(ad_sta, 8'h61, 2'b00, 2'b01);
		send_n(1);
		rd(ad_sta, 8'h61, 2'b01, 2'b01);
		send_n(1);
		wr(ad_lvl, 8'h00);
		for (int t = 0; t < 4; t++) begin
			wr(ad_fct, {t[1:0], 6'h00});
			rd(ad_sta, 8'h61, {1'b0, t < 2}, 2'b01);
		end
		send_n(12);
		rd(ad_sta, 8'h61, 2'b01, 2'b01);
		send_n(1);
		rd(ad_sta, 8'h63, 2'b11, 2'b11);
		wr(ad_sta, 8'h05);
		rd(ad_lvl, 8'h10);
		rd(ad_sta, 8'h61, 2'b01, 2'b11);
		repeat (16) rd(ad_dat, 8'h00);
		rd(ad_sta, 8'h60, 2'b00, 2'b01);
		rd(ad_lvl, 8'h00);
		$display("done threshold and overrun");
		complete_run();
	end
endmodule
bind ulsx_uart ulsx_monitor i_ulsx_monitor (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_fifo_empty_flag(tx_fifo_empty_flag), .tx_all_empty(tx_all_empty),
	.line_status_irq(line_status_irq), .tx_empty_irq(tx_empty_irq),
	.rx_data_irq(rx_data_irq));
